// ---- cvta_addr_map.v ----
`timescale 1ns/1ns
// Counter-to-output address mapping for byte, word and doubleword modes
module cvta_addr_map (
  // Counter and selects
  input  wire [15:0] counter,
  input  wire        dword_mode,
  input  wire        byte_mode,
  input  wire        addr_wrap,
  // Mapped address
  output reg  [15:0] mapped
);
  // Doubleword overrides byte/word selection
  always @* begin
    if (dword_mode) begin
      mapped = {counter[13:0], counter[13], counter[12]};
    end else if (!byte_mode) begin
      mapped = {counter[14:0], addr_wrap ? counter[15] : counter[13]};
    end else begin
      mapped = counter;
    end
  end
endmodule

// ---- cvta_clk_div.v ----
`timescale 1ns/1ns
// Enable divider: passes every first, second or fourth input enable
module cvta_clk_div (
  // Clock and reset
  input  wire clock,
  input  wire rst,
  // Control
  input  wire in_en,
  input  wire div2,
  input  wire div4,
  // Divided enable
  output wire out_en
);
  reg [1:0] phase_reg;

  // Free-running phase of input enables
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_reg <= 2'h0;
    end else if (in_en) begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  // Div4 takes priority; intended for doubleword
  assign out_en = in_en & (div4 ? (phase_reg == 2'h3) :
                           div2 ? phase_reg[0] : 1'b1);
endmodule

// ---- cvta_monitor_model.sv ----
`timescale 1ns/1ns
// Monitor side: measures lines per frame and blanked lines per frame
module cvta_monitor_model (
  // Clock and reset
  input  wire       clock,
  input  wire       rst,
  // Sync and blank from the block
  input  wire       hline_en,
  input  wire       vdisp_en,
  input  wire       vblank,
  // Last complete frame
  output reg  [7:0] frame_lines,
  output reg  [7:0] blank_lines
);
  reg [7:0] line_cnt_reg;
  reg [7:0] blank_cnt_reg;
  reg       vdisp_d_reg;

  // A frame starts where display enable rises
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      frame_lines <= 8'h00;
      blank_lines <= 8'h00;
      line_cnt_reg <= 8'h00;
      blank_cnt_reg <= 8'h00;
      vdisp_d_reg <= 1'b0;
    end else begin
      vdisp_d_reg <= vdisp_en;
      if (vdisp_en && !vdisp_d_reg) begin
        frame_lines <= line_cnt_reg;
        blank_lines <= blank_cnt_reg;
        line_cnt_reg <= 8'h00;
        blank_cnt_reg <= 8'h00;
      end else if (hline_en) begin
        line_cnt_reg <= line_cnt_reg + 8'h01;
        blank_cnt_reg <= blank_cnt_reg + {7'h00, vblank};
      end
    end
  end
endmodule

// ---- cvta_regs.vh ----
`ifndef CVTA_REGS_VH
`define CVTA_REGS_VH
// Register indices behind the index/data port pair
`define CVTA_IDX_OVERFLOW      5'h07
`define CVTA_IDX_MAX_SCAN      5'h09
`define CVTA_IDX_RETRACE_START 5'h10
`define CVTA_IDX_RETRACE_END   5'h11
`define CVTA_IDX_DISP_END      5'h12
`define CVTA_IDX_ROW_OFFSET    5'h13
`define CVTA_IDX_UNDERLINE     5'h14
`define CVTA_IDX_BLANK_START   5'h15
`define CVTA_IDX_BLANK_END     5'h16
`define CVTA_IDX_MODE_CTL      5'h17
`define CVTA_IDX_SPLIT_LINE    5'h18
// Overflow register fields
`define CVTA_OVF_DISP_END8     1
`define CVTA_OVF_RETR_START8   2
`define CVTA_OVF_BLANK_START8  3
`define CVTA_OVF_SPLIT8        4
`define CVTA_OVF_DISP_END9     6
`define CVTA_OVF_RETR_START9   7
// Max scan line register fields
`define CVTA_MSL_BLANK_START9  5
`define CVTA_MSL_SPLIT9        6
// Underline register fields
`define CVTA_UL_DWORD          6
`define CVTA_UL_COUNT4         5
// Mode control fields
`define CVTA_MC_RETRACE_EN     7
`define CVTA_MC_BYTE_MODE      6
`define CVTA_MC_ADDR_WRAP      5
`define CVTA_MC_COUNT2         3
`define CVTA_MC_VCLK_DIV2      2
`define CVTA_MC_ROW14_SEL      1
`define CVTA_MC_ROW13_SEL      0
// Reset values
`define CVTA_REG_RESET         8'h00
`define CVTA_MODE_RESET        8'h00
`endif

// ---- cvta_top.v ----
`timescale 1ns/1ns
`include "cvta_regs.vh"
module cvta_top #(
  parameter ADDR_W = 16,
  parameter LINE_W = 10
) (
  // Clock and reset
  input  wire              clock,
  input  wire              rst,
  // Indexed register port
  input  wire              index_wr,
  input  wire              data_wr,
  input  wire              data_rd,
  input  wire [7:0]        wdata,
  output reg  [7:0]        rdata,
  // Timing inputs
  input  wire              char_en,
  input  wire              hline_en,
  input  wire              hdisp_active,
  input  wire              hretrace_in,
  input  wire [15:0]       start_addr,
  // Display memory and monitor outputs
  output reg  [ADDR_W-1:0] refresh_addr,
  output reg               vdisp_en,
  output reg               vblank,
  output reg               vretrace,
  output reg               hretrace,
  output reg               underline,
  output reg  [4:0]        row_scan
);
  reg [4:0]        index_reg;
  reg [7:0]        overflow_reg;
  reg [7:0]        max_scan_reg;
  reg [7:0]        retr_start_reg;
  reg [7:0]        retr_end_reg;
  reg [7:0]        vert_display_end_low_reg;
  reg [7:0]        row_offset_reg;
  reg [7:0]        underline_and_addr_width_reg;
  reg [7:0]        vert_blank_start_low_reg;
  reg [7:0]        vert_blank_end_reg;
  reg [7:0]        timing_mode_control_reg;
  reg [7:0]        split_line_target_low_reg;
  reg [LINE_W-1:0] vline_reg;
  reg              vhalf_reg;
  reg [15:0]       row_start_reg;
  reg [15:0]       counter_reg;
  reg [15:0]       counter_next;
  wire [LINE_W-1:0] disp_end;
  wire [LINE_W-1:0] blank_start;
  wire [LINE_W-1:0] split_target;
  wire [LINE_W-1:0] retr_start;
  wire              dword_mode;
  wire              addr_en;
  wire              vline_en;
  wire              last_scan;
  wire [15:0]       mapped;
  wire [15:0]       row_step;
  reg  [15:0]       subst;
  reg  [15:0]       row_start_next;
  wire              split_hit;
  wire              frame_wrap;

  // One more than a line value; blank start, frame wrap and stepping need it
  function [LINE_W-1:0] line_plus1;
    input [LINE_W-1:0] line;
    begin
      line_plus1 = line + {{(LINE_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // Ten-bit values assembled from split register fields
  assign disp_end = {overflow_reg[`CVTA_OVF_DISP_END9],
                     overflow_reg[`CVTA_OVF_DISP_END8],
                     vert_display_end_low_reg};
  assign blank_start = {max_scan_reg[`CVTA_MSL_BLANK_START9],
                        overflow_reg[`CVTA_OVF_BLANK_START8],
                        vert_blank_start_low_reg};
  assign split_target = {max_scan_reg[`CVTA_MSL_SPLIT9],
                         overflow_reg[`CVTA_OVF_SPLIT8],
                         split_line_target_low_reg};
  assign retr_start = {overflow_reg[`CVTA_OVF_RETR_START9],
                       overflow_reg[`CVTA_OVF_RETR_START8],
                       retr_start_reg};
  assign dword_mode = underline_and_addr_width_reg[`CVTA_UL_DWORD];

  // Index latch, then data write to the selected register
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      index_reg                    <= 5'h00;
      overflow_reg                 <= `CVTA_REG_RESET;
      max_scan_reg                 <= `CVTA_REG_RESET;
      retr_start_reg               <= `CVTA_REG_RESET;
      retr_end_reg                 <= `CVTA_REG_RESET;
      vert_display_end_low_reg     <= `CVTA_REG_RESET;
      row_offset_reg               <= `CVTA_REG_RESET;
      underline_and_addr_width_reg <= `CVTA_REG_RESET;
      vert_blank_start_low_reg     <= `CVTA_REG_RESET;
      vert_blank_end_reg           <= `CVTA_REG_RESET;
      timing_mode_control_reg      <= `CVTA_MODE_RESET;
      split_line_target_low_reg    <= `CVTA_REG_RESET;
    end else if (index_wr) begin
      index_reg <= wdata[4:0];
    end else if (data_wr) begin
      if (index_reg == `CVTA_IDX_OVERFLOW) begin
        overflow_reg <= wdata;
      end else if (index_reg == `CVTA_IDX_MAX_SCAN) begin
        max_scan_reg <= wdata;
      end else if (index_reg == `CVTA_IDX_RETRACE_START) begin
        retr_start_reg <= wdata;
      end else if (index_reg == `CVTA_IDX_RETRACE_END) begin
        retr_end_reg <= wdata;
      end else if (index_reg == `CVTA_IDX_DISP_END) begin
        vert_display_end_low_reg <= wdata;
      end else if (index_reg == `CVTA_IDX_ROW_OFFSET) begin
        row_offset_reg <= wdata;
      end else if (index_reg == `CVTA_IDX_UNDERLINE) begin
        underline_and_addr_width_reg <= wdata;
      end else if (index_reg == `CVTA_IDX_BLANK_START) begin
        vert_blank_start_low_reg <= wdata;
      end else if (index_reg == `CVTA_IDX_BLANK_END) begin
        vert_blank_end_reg <= wdata;
      end else if (index_reg == `CVTA_IDX_MODE_CTL) begin
        timing_mode_control_reg <= wdata;
      end else if (index_reg == `CVTA_IDX_SPLIT_LINE) begin
        split_line_target_low_reg <= wdata;
      end
    end
  end

  // Registered read data; unmapped indices read zero
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (data_rd) begin
      if (index_reg == `CVTA_IDX_OVERFLOW) begin
        rdata <= overflow_reg;
      end else if (index_reg == `CVTA_IDX_MAX_SCAN) begin
        rdata <= max_scan_reg;
      end else if (index_reg == `CVTA_IDX_RETRACE_START) begin
        rdata <= retr_start_reg;
      end else if (index_reg == `CVTA_IDX_RETRACE_END) begin
        rdata <= retr_end_reg;
      end else if (index_reg == `CVTA_IDX_DISP_END) begin
        rdata <= vert_display_end_low_reg;
      end else if (index_reg == `CVTA_IDX_ROW_OFFSET) begin
        rdata <= row_offset_reg;
      end else if (index_reg == `CVTA_IDX_UNDERLINE) begin
        rdata <= underline_and_addr_width_reg;
      end else if (index_reg == `CVTA_IDX_BLANK_START) begin
        rdata <= vert_blank_start_low_reg;
      end else if (index_reg == `CVTA_IDX_BLANK_END) begin
        rdata <= vert_blank_end_reg;
      end else if (index_reg == `CVTA_IDX_MODE_CTL) begin
        rdata <= timing_mode_control_reg;
      end else if (index_reg == `CVTA_IDX_SPLIT_LINE) begin
        rdata <= split_line_target_low_reg;
      end else begin
        rdata <= 8'h00;
      end
    end
  end

  // Address counter advance rate
  cvta_clk_div u_addr_div (
    .clock  (clock),
    .rst    (rst),
    .in_en  (char_en & hdisp_active & vdisp_en),
    .div2   (timing_mode_control_reg[`CVTA_MC_COUNT2]),
    .div4   (underline_and_addr_width_reg[`CVTA_UL_COUNT4]),
    .out_en (addr_en)
  );

  // Vertical counter clock, optionally half line rate
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      vhalf_reg <= 1'b0;
    end else if (hline_en) begin
      vhalf_reg <= ~vhalf_reg;
    end
  end
  assign vline_en = hline_en &
                    (~timing_mode_control_reg[`CVTA_MC_VCLK_DIV2] | vhalf_reg);

  // Row step is offset scaled by two, or four in doubleword
  assign row_step = dword_mode ? {6'h00, row_offset_reg, 2'h0}
                               : {7'h00, row_offset_reg, 1'h0};
  assign last_scan = (row_scan == max_scan_reg[4:0]);

  // Line events; split match wins over frame wrap
  assign split_hit  = (vline_reg == split_target);
  assign frame_wrap = (vline_reg == line_plus1(disp_end));

  // Next line start, shared by the row start and the address counter
  always @* begin
    row_start_next = row_start_reg;
    if (split_hit) begin
      row_start_next = 16'h0000;
    end else if (frame_wrap) begin
      row_start_next = start_addr;
    end else if (last_scan) begin
      row_start_next = row_start_reg + row_step;
    end
  end

  // Vertical line, row scan and line start tracking
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      vline_reg     <= {LINE_W{1'b0}};
      row_scan      <= 5'h00;
      row_start_reg <= 16'h0000;
    end else if (vline_en) begin
      vline_reg     <= line_plus1(vline_reg);
      row_start_reg <= row_start_next;
      if (split_hit) begin
        row_scan <= 5'h00;
      end else if (frame_wrap) begin
        vline_reg <= {LINE_W{1'b0}};
        row_scan  <= 5'h00;
      end else if (last_scan) begin
        row_scan <= 5'h00;
      end else begin
        row_scan <= row_scan + 5'h01;
      end
    end
  end

  // Counter loads the new line start; the old one would repeat a row
  always @* begin
    counter_next = counter_reg;
    if (vline_en) begin
      counter_next = row_start_next;
    end else if (addr_en) begin
      counter_next = counter_reg + 16'h0001;
    end
  end
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      counter_reg <= 16'h0000;
    end else begin
      counter_reg <= counter_next;
    end
  end

  cvta_addr_map u_map (
    .counter    (counter_reg),
    .dword_mode (dword_mode),
    .byte_mode  (timing_mode_control_reg[`CVTA_MC_BYTE_MODE]),
    .addr_wrap  (timing_mode_control_reg[`CVTA_MC_ADDR_WRAP]),
    .mapped     (mapped)
  );

  // Row scan substitution on bits 13 and 14
  always @* begin
    subst = mapped;
    if (!timing_mode_control_reg[`CVTA_MC_ROW14_SEL]) begin
      subst[14] = row_scan[1];
    end
    if (!timing_mode_control_reg[`CVTA_MC_ROW13_SEL] && vdisp_en) begin
      subst[13] = row_scan[0];
    end
  end

  // Registered outputs; retrace disable touches nothing else
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      refresh_addr <= {ADDR_W{1'b0}};
      vdisp_en     <= 1'b0;
      vblank       <= 1'b0;
      vretrace     <= 1'b0;
      hretrace     <= 1'b0;
      underline    <= 1'b0;
    end else begin
      refresh_addr <= subst[ADDR_W-1:0];
      vdisp_en     <= (vline_reg <= disp_end);
      underline    <= (row_scan == underline_and_addr_width_reg[4:0] + 5'h01);
      if (vline_reg == line_plus1(blank_start)) begin
        vblank <= 1'b1;
      end else if (vline_reg[7:0] == vert_blank_end_reg) begin
        vblank <= 1'b0;
      end
      hretrace <= hretrace_in & timing_mode_control_reg[`CVTA_MC_RETRACE_EN];
      if (!timing_mode_control_reg[`CVTA_MC_RETRACE_EN]) begin
        vretrace <= 1'b0;
      end else if (vline_reg == retr_start) begin
        vretrace <= 1'b1;
      end else if (vline_reg[3:0] == retr_end_reg[3:0]) begin
        vretrace <= 1'b0;
      end
    end
  end
endmodule

// ---- cvta_top_chk.sv ----
`timescale 1ns/1ns
`include "cvta_regs.vh"
// Port-level checks for the vertical timing and refresh address block
module cvta_top_chk #(
  parameter ADDR_W = 16,
  parameter LINE_W = 10
) (
  // Clock and reset
  input wire              clock,
  input wire              rst,
  // Register port
  input wire              index_wr,
  input wire              data_wr,
  input wire              data_rd,
  input wire [7:0]        wdata,
  input wire [7:0]        rdata,
  // Timing inputs
  input wire              char_en,
  input wire              hline_en,
  input wire              hdisp_active,
  input wire              hretrace_in,
  input wire [15:0]       start_addr,
  // Memory and monitor outputs
  input wire [ADDR_W-1:0] refresh_addr,
  input wire              vdisp_en,
  input wire              vblank,
  input wire              vretrace,
  input wire              hretrace,
  input wire              underline,
  input wire [4:0]        row_scan
);
  reg  [4:0] idx_reg;
  reg  [7:0] mode_reg;
  reg  [7:0] ul_reg;
  wire       known = idx_reg == 5'h07 || idx_reg == 5'h09 || (idx_reg >= 5'h10 && idx_reg <= 5'h18);

  // Shadow copies, updated on the same edge as the block's own registers
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      idx_reg <= 5'h00;
      mode_reg <= 8'h00;
      ul_reg <= 8'h00;
    end else if (index_wr) begin
      idx_reg <= wdata[4:0];
    end else if (data_wr) begin
      if (idx_reg == `CVTA_IDX_MODE_CTL) mode_reg <= wdata;
      if (idx_reg == `CVTA_IDX_UNDERLINE) ul_reg <= wdata;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  retrace_hold_a: assert property (!mode_reg[7] |=> !hretrace && !vretrace)
    else $error("retrace seen while held off");
  hretrace_pass_a: assert property (mode_reg[7] && hretrace_in |=> hretrace)
    else $error("horizontal retrace not passed");
  read_mode_a: assert property (data_rd && idx_reg == 5'h17 |=> rdata == mode_reg)
    else $error("mode register read wrong");
  read_unmapped_a: assert property (data_rd && !known |=> rdata == 8'h00)
    else $error("unmapped index read not zero");
  rdata_hold_a: assert property (!data_rd |=> $stable(rdata))
    else $error("read data moved without a read");
  underline_row_a: assert property (underline == $past(row_scan == ul_reg[4:0] + 5'd1))
    else $error("underline on wrong scan line");
  row_step_a: assert property ($changed(row_scan) |-> $past(hline_en))
    else $error("row scan moved without a line pulse");
  // Address may move only after a character, line or register event
  addr_quiet_a: assert property ((!char_en && !hline_en && !data_wr) [*3] |=> $stable(refresh_addr))
    else $error("refresh address moved while idle");

  cover property (data_rd && idx_reg == 5'h17);
  cover property ($rose(underline));
  cover property ($rose(hretrace));
endmodule

bind cvta_top cvta_top_chk #(.ADDR_W(ADDR_W), .LINE_W(LINE_W)) cvta_top_chk_i (
  .clock(clock), .rst(rst), .index_wr(index_wr), .data_wr(data_wr), .data_rd(data_rd),
  .wdata(wdata), .rdata(rdata), .char_en(char_en), .hline_en(hline_en),
  .hdisp_active(hdisp_active), .hretrace_in(hretrace_in), .start_addr(start_addr),
  .refresh_addr(refresh_addr), .vdisp_en(vdisp_en), .vblank(vblank), .vretrace(vretrace),
  .hretrace(hretrace), .underline(underline), .row_scan(row_scan));

// ---- test_crt_vertical_timing_addr.sv ----
`timescale 1ns/1ns
// Self-checking bench for the vertical timing and refresh address block
module test_crt_vertical_timing_addr;
  reg         clock = 1'b0;
  reg         rst = 1'b1;
  reg         index_wr = 1'b0;
  reg         data_wr = 1'b0;
  reg         data_rd = 1'b0;
  reg  [7:0]  wdata = 8'h00;
  reg         char_en = 1'b0;
  reg         hline_en = 1'b0;
  reg         hdisp_active = 1'b1;
  reg         hretrace_in = 1'b0;
  reg  [15:0] start_addr = 16'h9234;
  wire [7:0]  rdata;
  wire [15:0] refresh_addr;
  wire        vdisp_en, vblank, vretrace, hretrace, underline;
  wire [4:0]  row_scan;
  wire [7:0]  frame_lines, blank_lines;
  integer     n_mismatch = 0;
  integer     checks = 0;
  integer     i, n;
  reg  [7:0]  v;

  // 250 MHz
  always #2 clock = ~clock;

  cvta_top #(.ADDR_W(16), .LINE_W(10)) cvta_top_i (
    .clock(clock), .rst(rst), .index_wr(index_wr), .data_wr(data_wr), .data_rd(data_rd),
    .wdata(wdata), .rdata(rdata), .char_en(char_en), .hline_en(hline_en),
    .hdisp_active(hdisp_active), .hretrace_in(hretrace_in), .start_addr(start_addr),
    .refresh_addr(refresh_addr), .vdisp_en(vdisp_en), .vblank(vblank), .vretrace(vretrace),
    .hretrace(hretrace), .underline(underline), .row_scan(row_scan));
  cvta_monitor_model cvta_monitor_model_i (.clock(clock), .rst(rst), .hline_en(hline_en),
    .vdisp_en(vdisp_en), .vblank(vblank), .frame_lines(frame_lines), .blank_lines(blank_lines));

  task chk(input [15:0] seen, input [15:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // Index first, then the data access
  task wr(input [4:0] idx, input [7:0] val);
    begin
      @(negedge clock) index_wr = 1'b1;
      wdata = {3'h0, idx};
      @(negedge clock) index_wr = 1'b0;
      data_wr = 1'b1;
      wdata = val;
      @(negedge clock) data_wr = 1'b0;
    end
  endtask

  task rd(input [4:0] idx);
    begin
      @(negedge clock) index_wr = 1'b1;
      wdata = {3'h0, idx};
      @(negedge clock) index_wr = 1'b0;
      data_rd = 1'b1;
      @(negedge clock) data_rd = 1'b0;
      v = rdata;
    end
  endtask

  // One line pulse, then time for the registered outputs to settle
  task hl;
    begin
      @(negedge clock) hline_en = 1'b1;
      @(negedge clock) hline_en = 1'b0;
      repeat (4) @(negedge clock);
    end
  endtask

  // Run lines until display enable has fallen and risen again
  task frame;
    begin
      n = 0;
      while (vdisp_en === 1'b1 && n < 40) begin
        hl;
        n = n + 1;
      end
      while (vdisp_en !== 1'b1 && n < 40) begin
        hl;
        n = n + 1;
      end
      if (n >= 40) chk(16'h0000, 16'h0001);
    end
  endtask

  function [15:0] mapf(input [15:0] c, input [1:0] m);
    case (m)
      2'd0: mapf = c;
      2'd1: mapf = {c[14:0], c[15]};
      2'd2: mapf = {c[14:0], c[13]};
      default: mapf = {c[13:0], c[13], c[12]};
    endcase
  endfunction

  task complete_run;
    begin
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge clock);
    @(negedge clock) rst = 1'b0;
    for (i = 0; i < 11; i = i + 1) begin
      n = i < 2 ? 7 + 2 * i : 14 + i;
      rd(n[4:0]);
      chk(v, 8'h00);
      wr(n[4:0], 8'hA0 | n[7:0]);
      rd(n[4:0]);
      chk(v, 8'hA0 | n[7:0]);
    end
    wr(5'h1F, 8'hFF);
    rd(5'h1F);
    chk(v, 8'h00);
    $display("test registers done");
    hretrace_in = 1'b1;
    wr(5'h17, 8'h00);
    repeat (3) @(negedge clock);
    chk({hretrace, vretrace}, 2'b00);
    rd(5'h13);
    chk(v, 8'hB3);
    wr(5'h17, 8'hC3);
    repeat (3) @(negedge clock);
    chk(hretrace, 1'b1);
    hretrace_in = 1'b0;
    $display("test retrace gate done");
    // Six displayed lines, four scans a row, blank on lines 3 and 4
    wr(5'h07, 8'h10);
    wr(5'h09, 8'h43);
    wr(5'h18, 8'hFF);
    wr(5'h12, 8'h05);
    wr(5'h13, 8'h03);
    wr(5'h14, 8'h01);
    wr(5'h15, 8'h02);
    wr(5'h16, 8'h05);
    wr(5'h10, 8'h01);
    wr(5'h11, 8'h03);
    frame;
    for (i = 0; i < 6; i = i + 1) begin
      chk(row_scan, {14'h0, i[1:0]});
      chk(underline, i == 2);
      chk(vblank, i == 3 || i == 4);
      chk(vretrace, i == 1 || i == 2);
      chk(refresh_addr, start_addr + (i > 3 ? 16'h0006 : 16'h0000));
      hl;
    end
    frame;
    chk(frame_lines, 8'd7);
    chk(blank_lines, 8'd2);
    wr(5'h17, 8'hC7);
    frame;
    frame;
    chk(frame_lines, 8'd14);
    $display("test vertical timing done");
    for (i = 0; i < 4; i = i + 1) begin
      wr(5'h17, i == 1 ? 8'hA3 : i == 2 ? 8'h83 : 8'hC3);
      wr(5'h14, i == 3 ? 8'h41 : 8'h01);
      frame;
      chk(refresh_addr, mapf(start_addr, i[1:0]));
    end
    wr(5'h14, 8'h01);
    wr(5'h17, 8'hC0);
    frame;
    for (i = 0; i < 4; i = i + 1) begin
      chk(refresh_addr, {start_addr[15], i[1], i[0], start_addr[12:0]});
      hl;
    end
    $display("test address mapping done");
    // Eight character pulses give eight, four or two steps
    for (i = 0; i < 3; i = i + 1) begin
      wr(5'h17, i == 1 ? 8'hCB : 8'hC3);
      wr(5'h14, i == 2 ? 8'h21 : 8'h01);
      frame;
      @(negedge clock) char_en = 1'b1;
      repeat (8) @(negedge clock);
      char_en = 1'b0;
      repeat (3) @(negedge clock);
      chk(refresh_addr, start_addr + (16'h0008 >> i));
    end
    $display("test counter clocking done");
    wr(5'h07, 8'h00);
    wr(5'h09, 8'h03);
    wr(5'h18, 8'h02);
    wr(5'h17, 8'hC3);
    wr(5'h14, 8'h01);
    frame;
    hl;
    hl;
    chk(refresh_addr, start_addr);
    // Match is taken as the target line ends, so the next line starts at zero
    hl;
    chk(refresh_addr, 16'h0000);
    $display("test split screen done");
    complete_run;
  end

  // Whole run needs about a thousand cycles; the 25000-cycle limit allows ample margin
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    complete_run;
  end
endmodule
